// >>> hw/flash_seq_pkg.sv
// constants shared by the flash sequencer device and its controller
// Operation
// - status read and command write share one address
// - status bit 6 shows target address valid; code sets it on writes only, also needing the region's write enable
// - status bit 1 flags unknown command
// - write command programs and stalls processor
// - read command loads data byte, stalls
// - release stall with outcome in status; code sets bit 6 on writes only, reads leave it
// - code write takes even address, 16-bit data
// - data flash address is offset shifted plus base
// - data flash write takes low data byte
// - address and data loads in any order
// - each region needs its write enable bit
// - unlock keys 55h then AAh before enables
// - software clears enables after write batch
// - code readable through plain program-space loads
// - readout protect blocks programmer reads, not erase
// - programmer select idles high, active low
// - programming only while reset pin held high
// - 40-bit identifier laid out in program space
// - byte at 3FFBh is reserved, not identifier
// - unlock window lasts 13 to 23 cycles
// - data register pair at 8Eh and 8Fh
package flash_seq_pkg;
  localparam logic [7:0] SFR_ADDR_LO = 8'h84;
  localparam logic [7:0] SFR_ADDR_HI = 8'h85;
  localparam logic [7:0] SFR_STATUS = 8'h86;
  localparam logic [7:0] SFR_DATA_LO = 8'h8E;
  localparam logic [7:0] SFR_DATA_HI = 8'h8F;
  localparam logic [7:0] SFR_UNLOCK = 8'hA1;
  localparam logic [7:0] SFR_GCFG = 8'hB1;
  localparam int GCFG_CODE_WE_BIT = 7;
  localparam int GCFG_DATA_WE_BIT = 2;
  localparam int ST_VALID_BIT = 6;
  localparam int ST_CMDERR_BIT = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h9A;
  localparam logic [7:0] CMD_READ = 8'h8E;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [4:0] UNLOCK_CYCLES = 5'h12;
  localparam logic [7:0] WRITE_CYCLES = 8'h14;
  localparam logic [7:0] READ_CYCLES = 8'h04;
  localparam logic [15:0] CODE_LIMIT = 16'h3FF8;
  localparam logic [15:0] CFG_ADDR = 16'h3FF8;
  localparam logic [15:0] ID_TOP_ADDR = 16'h3FFA;
  localparam logic [15:0] ID_LOW_ADDR = 16'h3FFC;
  localparam logic [15:0] ID_MID_ADDR = 16'h3FFE;
  localparam logic [7:0] DATA_PAGE = 8'hC0;
  localparam logic [7:0] PCMD_READ = 8'hA5;
  localparam logic [7:0] PCMD_ERASE = 8'h5A;
  localparam logic [31:0] REG_SFR_REQ = 32'h0000_0000;
  localparam logic [31:0] REG_SFR_RES = 32'h0000_0004;
  localparam logic [31:0] REG_CODE_ADDR = 32'h0000_0008;
  localparam logic [31:0] REG_CODE_DATA = 32'h0000_000C;
  localparam logic [31:0] REG_PINS = 32'h0000_0010;
  localparam int REQ_RD_BIT = 16;
  localparam int BUSY_BIT = 31;
  localparam logic [3:0] PINS_RST = 4'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/flash_sfr_if.sv
// link between the flash sequencer device and its controller
`timescale 1ns/100ps
interface flash_sfr_if;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic stall;
  logic code_rd;
  logic [15:0] code_addr;
  logic [15:0] code_rdata;
  logic prog_rst;
  logic prog_select_n;
  logic prog_sck;
  logic prog_sdi;
  logic prog_sdo;
  modport dev (input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, code_rd, code_addr, prog_rst,
    prog_select_n, prog_sck, prog_sdi, output sfr_rdata, stall, code_rdata, prog_sdo);
  modport ctl (output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, code_rd, code_addr, prog_rst,
    prog_select_n, prog_sck, prog_sdi, input sfr_rdata, stall, code_rdata, prog_sdo);
endinterface

// >>> hw/flash_program_sequencer.sv
// flash program sequencer: sfr registers, stall sequencing, program space, programmer port
`timescale 1ns/100ps
module flash_program_sequencer #(
  parameter logic [39:0] UNIQUE_ID = 40'h12_3456_789A  // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  flash_sfr_if.dev bus,
  input wire logic cfg_read_enable,
  output logic prog_mode,
  output logic readout_enable
);
  typedef enum logic [0:0] {S_IDLE = 1'b0, S_BUSY = 1'b1} op_state_t;

  logic [15:0] code_mem [0:8191];
  logic [7:0] data_mem [0:127];
  op_state_t state_q;
  logic [15:0] addr_q;
  logic [15:0] data_q;
  logic [7:0] status_q;
  logic [7:0] rdata_q;
  logic [15:0] code_rdata_q;
  logic code_we_q, data_we_q, key_seen_q, stall_q;
  logic [4:0] unlock_cnt_q;
  logic [7:0] op_cnt_q;
  logic op_write_q, op_ok_q;
  logic started_q, read_en_q, prog_mode_q;
  logic sck_q, sdo_q, erase_q;
  logic [7:0] shift_q, out_q;
  logic [2:0] bit_cnt_q;
  logic [13:0] ptr_q;
  logic [12:0] erase_cnt_q;

  // decode
  wire sfr_hit_status = bus.sfr_wr && bus.sfr_addr == flash_seq_pkg::SFR_STATUS;
  wire cmd_go = sfr_hit_status && state_q == S_IDLE;
  wire cmd_is_write = bus.sfr_wdata == flash_seq_pkg::CMD_WRITE;
  wire cmd_is_read = bus.sfr_wdata == flash_seq_pkg::CMD_READ;
  wire in_code = addr_q < flash_seq_pkg::CODE_LIMIT;
  wire in_data = addr_q[15:8] == flash_seq_pkg::DATA_PAGE;
  wire addr_even = !addr_q[0];
  wire write_ok = addr_even && ((in_code && code_we_q) || (in_data && data_we_q));
  wire read_ok = addr_even && in_data;
  wire unlocked = unlock_cnt_q != 5'h00;
  wire unlock_wr = bus.sfr_wr && bus.sfr_addr == flash_seq_pkg::SFR_UNLOCK;
  wire prog_active = bus.prog_rst && !bus.prog_select_n;
  wire sck_rise = prog_active && bus.prog_sck && !sck_q;
  wire [7:0] serial_cmd = {shift_q[6:0], bus.prog_sdi};
  wire [15:0] ptr_word = code_mem[ptr_q[13:1]];
  wire [7:0] ptr_byte = ptr_q[0] ? ptr_word[15:8] : ptr_word[7:0];
  wire [15:0] cfg_word = {read_en_q, 15'h02FF};

  // sfr read mux
  function automatic logic [7:0] sfr_view(input logic [7:0] a);
    case (a)
      flash_seq_pkg::SFR_ADDR_LO: sfr_view = addr_q[7:0];
      flash_seq_pkg::SFR_ADDR_HI: sfr_view = addr_q[15:8];
      flash_seq_pkg::SFR_STATUS: sfr_view = status_q;
      flash_seq_pkg::SFR_DATA_LO: sfr_view = data_q[7:0];
      flash_seq_pkg::SFR_DATA_HI: sfr_view = data_q[15:8];
      flash_seq_pkg::SFR_GCFG: begin
        sfr_view = 8'h00;
        sfr_view[flash_seq_pkg::GCFG_CODE_WE_BIT] = code_we_q;
        sfr_view[flash_seq_pkg::GCFG_DATA_WE_BIT] = data_we_q;
      end
      default: sfr_view = 8'h00;
    endcase
  endfunction

  // program space view: code, configuration word, identifier, data flash
  logic [15:0] pspace;
  always_comb begin
    pspace = 16'h0000;
    if (bus.code_addr < flash_seq_pkg::CODE_LIMIT) begin
      pspace = code_mem[bus.code_addr[13:1]];
    end else if (bus.code_addr[15:1] == flash_seq_pkg::CFG_ADDR[15:1]) begin
      pspace = cfg_word;
    end else if (bus.code_addr[15:1] == flash_seq_pkg::ID_TOP_ADDR[15:1]) begin
      pspace = {8'h00, UNIQUE_ID[39:32]};
    end else if (bus.code_addr[15:1] == flash_seq_pkg::ID_LOW_ADDR[15:1]) begin
      pspace = UNIQUE_ID[15:0];
    end else if (bus.code_addr[15:1] == flash_seq_pkg::ID_MID_ADDR[15:1]) begin
      pspace = UNIQUE_ID[31:16];
    end else if (bus.code_addr[15:8] == flash_seq_pkg::DATA_PAGE) begin
      pspace = {8'h00, data_mem[bus.code_addr[7:1]]};
    end
  end

  // registers seen by the processor, unlock window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 16'h0000;
      data_q <= 16'h0000;
      rdata_q <= 8'h00;
      code_we_q <= 1'b0;
      data_we_q <= 1'b0;
      key_seen_q <= 1'b0;
      unlock_cnt_q <= 5'h00;
    end else begin
      if (bus.sfr_rd) begin
        rdata_q <= sfr_view(bus.sfr_addr);
      end
      if (bus.sfr_wr) begin
        case (bus.sfr_addr)
          flash_seq_pkg::SFR_ADDR_LO: addr_q[7:0] <= bus.sfr_wdata;
          flash_seq_pkg::SFR_ADDR_HI: addr_q[15:8] <= bus.sfr_wdata;
          flash_seq_pkg::SFR_DATA_LO: data_q[7:0] <= bus.sfr_wdata;
          flash_seq_pkg::SFR_DATA_HI: data_q[15:8] <= bus.sfr_wdata;
          flash_seq_pkg::SFR_GCFG: begin
            if (unlocked) begin
              code_we_q <= bus.sfr_wdata[flash_seq_pkg::GCFG_CODE_WE_BIT];
              data_we_q <= bus.sfr_wdata[flash_seq_pkg::GCFG_DATA_WE_BIT];
            end
          end
          default: begin
          end
        endcase
      end
      if (state_q == S_BUSY && op_cnt_q == 8'h00 && !op_write_q && op_ok_q) begin
        data_q[7:0] <= data_mem[addr_q[7:1]];
      end
      if (unlock_wr) begin
        if (bus.sfr_wdata == flash_seq_pkg::KEY_FIRST) begin
          key_seen_q <= 1'b1;
          unlock_cnt_q <= 5'h00;
        end else if (key_seen_q && bus.sfr_wdata == flash_seq_pkg::KEY_SECOND) begin
          key_seen_q <= 1'b0;
          unlock_cnt_q <= flash_seq_pkg::UNLOCK_CYCLES;
        end else begin
          key_seen_q <= 1'b0;
          unlock_cnt_q <= 5'h00;
        end
      end else if (unlocked) begin
        unlock_cnt_q <= unlock_cnt_q - 5'h01;
      end
    end
  end

  // command sequencer with stall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      status_q <= flash_seq_pkg::STATUS_RST;
      stall_q <= 1'b0;
      op_cnt_q <= 8'h00;
      op_write_q <= 1'b0;
      op_ok_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_go) begin
            if (cmd_is_write) begin
              status_q[flash_seq_pkg::ST_VALID_BIT] <= write_ok;
              status_q[flash_seq_pkg::ST_CMDERR_BIT] <= 1'b0;
              op_ok_q <= write_ok;
              op_write_q <= 1'b1;
              op_cnt_q <= flash_seq_pkg::WRITE_CYCLES - 8'h01;
              stall_q <= 1'b1;
              state_q <= S_BUSY;
            end else if (cmd_is_read) begin
              status_q[flash_seq_pkg::ST_CMDERR_BIT] <= 1'b0;
              op_ok_q <= read_ok;
              op_write_q <= 1'b0;
              op_cnt_q <= flash_seq_pkg::READ_CYCLES - 8'h01;
              stall_q <= 1'b1;
              state_q <= S_BUSY;
            end else begin
              status_q[flash_seq_pkg::ST_CMDERR_BIT] <= 1'b1;
            end
          end
        end
        S_BUSY: begin
          if (op_cnt_q == 8'h00) begin
            stall_q <= 1'b0;
            state_q <= S_IDLE;
          end else begin
            op_cnt_q <= op_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= S_IDLE;
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // flash arrays: program commit and programmer erase
  always_ff @(posedge aclk) begin
    if (state_q == S_BUSY && op_cnt_q == 8'h00 && op_write_q && op_ok_q) begin
      if (in_code) begin
        code_mem[addr_q[13:1]] <= data_q;
      end else begin
        data_mem[addr_q[7:1]] <= data_q[7:0];
      end
    end
    if (erase_q) begin
      code_mem[erase_cnt_q] <= 16'hFFFF;
      data_mem[erase_cnt_q[6:0]] <= 8'hFF;
    end
  end

  // programmer serial port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      started_q <= 1'b0;
      read_en_q <= 1'b0;
      prog_mode_q <= 1'b0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      shift_q <= 8'h00;
      out_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      ptr_q <= 14'h0000;
      erase_q <= 1'b0;
      erase_cnt_q <= 13'h0000;
    end else begin
      if (!started_q) begin
        started_q <= 1'b1;
        read_en_q <= cfg_read_enable;
      end
      prog_mode_q <= prog_active;
      sck_q <= bus.prog_sck;
      if (!prog_active) begin
        bit_cnt_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q <= serial_cmd;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        sdo_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
        if (bit_cnt_q == 3'h7) begin
          if (serial_cmd == flash_seq_pkg::PCMD_READ) begin
            out_q <= read_en_q ? ptr_byte : 8'h00;
            ptr_q <= ptr_q + 14'h0001;
          end else if (serial_cmd == flash_seq_pkg::PCMD_ERASE) begin
            erase_q <= 1'b1;
            erase_cnt_q <= 13'h0000;
            ptr_q <= 14'h0000;
          end
        end
      end
      if (erase_q) begin
        erase_cnt_q <= erase_cnt_q + 13'h0001;
        if (erase_cnt_q == 13'h1FFF) begin
          erase_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_rdata_q <= 16'h0000;
    end else if (bus.code_rd) begin
      code_rdata_q <= pspace;
    end
  end

  assign bus.sfr_rdata = rdata_q;
  assign bus.stall = stall_q;
  assign bus.code_rdata = code_rdata_q;
  assign bus.prog_sdo = sdo_q;
  assign prog_mode = prog_mode_q;
  assign readout_enable = read_en_q;
endmodule

// >>> hw/flash_sequencer_ctrl.sv
// controller end: axi4-lite registers driving the processor-side flash link
`timescale 1ns/100ps
module flash_sequencer_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  flash_sfr_if.ctl bus
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_ISSUE = 2'b01, C_WAIT = 2'b11} ctl_state_t;

  ctl_state_t state_q;
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0] wstrb_q, pins_q;
  logic sfr_wr_q, sfr_rd_q, code_rd_q, code_busy_q;
  logic [7:0] sfr_addr_q, sfr_wdata_q, res_q;
  logic [15:0] code_addr_q, code_data_q;

  function automatic logic reg_mapped(input logic [31:0] a);
    reg_mapped = a == flash_seq_pkg::REG_SFR_REQ || a == flash_seq_pkg::REG_SFR_RES ||
      a == flash_seq_pkg::REG_CODE_ADDR || a == flash_seq_pkg::REG_CODE_DATA ||
      a == flash_seq_pkg::REG_PINS;
  endfunction

  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire full_word = wstrb_q == 4'hF;
  wire sfr_busy = state_q != C_IDLE;
  wire wr_req = do_write && full_word && awaddr_q == flash_seq_pkg::REG_SFR_REQ && !sfr_busy;
  wire wr_code = do_write && full_word && awaddr_q == flash_seq_pkg::REG_CODE_ADDR &&
    !code_busy_q;
  wire wr_pins = do_write && full_word && awaddr_q == flash_seq_pkg::REG_PINS;
  wire [31:0] read_view =
    s_axi_araddr == flash_seq_pkg::REG_SFR_RES ? {sfr_busy, 23'h000000, res_q} :
    s_axi_araddr == flash_seq_pkg::REG_CODE_DATA ? {code_busy_q, 15'h0000, code_data_q} :
    s_axi_araddr == flash_seq_pkg::REG_PINS ? {27'h0000000, bus.prog_sdo, pins_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= flash_seq_pkg::RESP_OKAY;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      awready_q <= !aw_have_q && !awready_q;
      wready_q <= !w_have_q && !wready_q;
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= reg_mapped(awaddr_q) ? flash_seq_pkg::RESP_OKAY : flash_seq_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= flash_seq_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !arready_q;
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= read_view;
        rresp_q <= reg_mapped(s_axi_araddr) ? flash_seq_pkg::RESP_OKAY :
          flash_seq_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // processor-side access: one pulse, then wait out the stall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= C_IDLE;
      sfr_wr_q <= 1'b0;
      sfr_rd_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wdata_q <= 8'h00;
      res_q <= 8'h00;
    end else begin
      case (state_q)
        C_IDLE: begin
          if (wr_req) begin
            sfr_addr_q <= wdata_q[15:8];
            sfr_wdata_q <= wdata_q[7:0];
            sfr_rd_q <= wdata_q[flash_seq_pkg::REQ_RD_BIT];
            sfr_wr_q <= !wdata_q[flash_seq_pkg::REQ_RD_BIT];
            state_q <= C_ISSUE;
          end
        end
        C_ISSUE: begin
          sfr_wr_q <= 1'b0;
          sfr_rd_q <= 1'b0;
          state_q <= C_WAIT;
        end
        C_WAIT: begin
          if (!bus.stall) begin
            res_q <= bus.sfr_rdata;
            state_q <= C_IDLE;
          end
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_rd_q <= 1'b0;
      code_busy_q <= 1'b0;
      code_addr_q <= 16'h0000;
      code_data_q <= 16'h0000;
      pins_q <= flash_seq_pkg::PINS_RST;
    end else begin
      code_rd_q <= wr_code;
      if (wr_code) begin
        code_addr_q <= wdata_q[15:0];
        code_busy_q <= 1'b1;
      end else if (code_busy_q && !code_rd_q) begin
        code_data_q <= bus.code_rdata;
        code_busy_q <= 1'b0;
      end
      if (wr_pins) begin
        pins_q <= wdata_q[3:0];
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign bus.sfr_wr = sfr_wr_q;
  assign bus.sfr_rd = sfr_rd_q;
  assign bus.sfr_addr = sfr_addr_q;
  assign bus.sfr_wdata = sfr_wdata_q;
  assign bus.code_rd = code_rd_q;
  assign bus.code_addr = code_addr_q;
  assign bus.prog_rst = pins_q[0];
  assign bus.prog_select_n = pins_q[1];
  assign bus.prog_sck = pins_q[2];
  assign bus.prog_sdi = pins_q[3];
endmodule

// >>> verification/flash_seq_props.sv
// concurrent checks on the link between the flash sequencer and its controller
`timescale 1ns/100ps
module flash_seq_props #(
  parameter logic [39:0] UNIQUE_ID = 40'h00_0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic stall,
  input wire logic code_rd,
  input wire logic [15:0] code_addr,
  input wire logic [15:0] code_rdata
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic cmd_wr;
  wire logic bad_cmd;
  assign cmd_wr = sfr_wr && !stall && sfr_addr == flash_seq_pkg::SFR_STATUS;
  assign bad_cmd = sfr_wdata != flash_seq_pkg::CMD_WRITE && sfr_wdata != flash_seq_pkg::CMD_READ;
  chk_write_stall: assert property (
    cmd_wr && sfr_wdata == flash_seq_pkg::CMD_WRITE |=>
    stall [*8] ##1 stall [*8] ##1 stall [*4] ##1 !stall)
    else $error("write command stall length wrong");
  chk_read_stall: assert property (
    cmd_wr && sfr_wdata == flash_seq_pkg::CMD_READ |=> stall [*4] ##1 !stall)
    else $error("read command stall length wrong");
  chk_bad_release: assert property (cmd_wr && bad_cmd |=> !stall)
    else $error("unknown command stalled the processor");
  chk_stall_cause: assert property ($rose(stall) |-> $past(cmd_wr) && !$past(bad_cmd))
    else $error("stall rose without a valid command");
  chk_status_zeros: assert property (
    sfr_rd && sfr_addr == flash_seq_pkg::SFR_STATUS |=> (sfr_rdata & 8'hBD) == 8'h00)
    else $error("reserved status bits not zero");
  chk_id_low: assert property (
    code_rd && code_addr == flash_seq_pkg::ID_LOW_ADDR |=> code_rdata == UNIQUE_ID[15:0])
    else $error("identifier low word wrong");
  chk_id_mid: assert property (
    code_rd && code_addr == flash_seq_pkg::ID_MID_ADDR |=> code_rdata == UNIQUE_ID[31:16])
    else $error("identifier middle word wrong");
  chk_id_top: assert property (
    code_rd && code_addr == flash_seq_pkg::ID_TOP_ADDR |=>
    code_rdata == {8'h00, UNIQUE_ID[39:32]})
    else $error("identifier top word wrong");
endmodule

// >>> verification/test_flash_program_sequencer.sv
// self-checking bench: axi controller driving the flash sequencer device
`timescale 1ns/100ps
module test_flash_program_sequencer;
  localparam logic [39:0] ID = 40'h5E_6D7C_8B9A;  // arbitrary value
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, prog_mode, readout_enable;
  logic [1:0] bresp, rresp, r;
  logic [7:0] q;
  int fail_count = 0;
  int compares = 0;
  flash_sfr_if link ();
  always #10 aclk = ~aclk;
  flash_program_sequencer #(.UNIQUE_ID(ID)) flash_program_sequencer_i (.aclk(aclk),
    .aresetn(aresetn), .bus(link.dev), .cfg_read_enable(1'b0), .prog_mode(prog_mode),
    .readout_enable(readout_enable));
  flash_sequencer_ctrl flash_sequencer_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(link.ctl));
  flash_seq_props #(.UNIQUE_ID(ID)) flash_seq_props_i (.aclk(aclk), .aresetn(aresetn),
    .sfr_wr(link.sfr_wr), .sfr_rd(link.sfr_rd), .sfr_addr(link.sfr_addr),
    .sfr_wdata(link.sfr_wdata), .sfr_rdata(link.sfr_rdata), .stall(link.stall),
    .code_rd(link.code_rd), .code_addr(link.code_addr), .code_rdata(link.code_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      fail_count++;
      $display("[ERR] t=%0t wait=%h limit=%h", $time, n, 60);
      print_verdict();
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok && bvalid));
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // one processor access, then wait until the controller is idle
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic is_rd);
    int n;
    n = 0;
    axi_wr(flash_seq_pkg::REG_SFR_REQ, {15'h0000, is_rd, a, d});
    do begin
      axi_rd(flash_seq_pkg::REG_SFR_RES);
      n++;
      tmo(n);
    end while (v[31]);
    q = v[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr(a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a);
    sfr(a, 8'h00, 1'b1);
  endtask
  task automatic crd(input logic [15:0] a);
    int n;
    n = 0;
    axi_wr(flash_seq_pkg::REG_CODE_ADDR, {16'h0000, a});
    do begin
      axi_rd(flash_seq_pkg::REG_CODE_DATA);
      n++;
      tmo(n);
    end while (v[31]);
  endtask
  task automatic unlock();
    wr(flash_seq_pkg::SFR_UNLOCK, flash_seq_pkg::KEY_FIRST);
    wr(flash_seq_pkg::SFR_UNLOCK, flash_seq_pkg::KEY_SECOND);
  endtask
  // data registers before address registers
  task automatic ld(input logic [15:0] a, input logic [15:0] d);
    wr(flash_seq_pkg::SFR_DATA_HI, d[15:8]);
    wr(flash_seq_pkg::SFR_DATA_LO, d[7:0]);
    wr(flash_seq_pkg::SFR_ADDR_HI, a[15:8]);
    wr(flash_seq_pkg::SFR_ADDR_LO, a[7:0]);
  endtask
  task automatic cmd_chk(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
    wr(flash_seq_pkg::SFR_STATUS, c);
    rd(flash_seq_pkg::SFR_STATUS);
    chk(q & m, e);
  endtask
  task automatic t_reset();
    rd(flash_seq_pkg::SFR_STATUS);
    chk(q, flash_seq_pkg::STATUS_RST);
    axi_rd(32'h0000_0040);
    chk(r, flash_seq_pkg::RESP_SLVERR);
    axi_rd(flash_seq_pkg::REG_PINS);
    chk(v[3:0], flash_seq_pkg::PINS_RST);
    crd(flash_seq_pkg::CFG_ADDR);
    chk({v[15], readout_enable}, 2'b00);
  endtask
  task automatic t_writes();
    unlock();
    wr(flash_seq_pkg::SFR_GCFG, 8'h84);
    ld(16'h0020, 16'hC35B);
    cmd_chk(flash_seq_pkg::CMD_WRITE, 8'hFF, 8'h40);
    crd(16'h0020);
    chk(v[15:0], 16'hC35B);
    ld(16'h0021, 16'h1234);
    cmd_chk(flash_seq_pkg::CMD_WRITE, 8'hFF, 8'h00);
    ld({flash_seq_pkg::DATA_PAGE, 7'h7F, 1'b0}, 16'h11A6);
    cmd_chk(flash_seq_pkg::CMD_WRITE, 8'hFF, 8'h40);
    crd({flash_seq_pkg::DATA_PAGE, 8'hFE});
    chk(v[15:0], 16'h00A6);
    wr(flash_seq_pkg::SFR_DATA_LO, 8'h00);
    cmd_chk(flash_seq_pkg::CMD_READ, 8'hFF, 8'h40);
    rd(flash_seq_pkg::SFR_DATA_LO);
    chk(q, 8'hA6);
  endtask
  task automatic t_bad_lock();
    cmd_chk(8'h33, 8'hBF, 8'h02);
    cmd_chk(flash_seq_pkg::CMD_READ, 8'hBF, 8'h00);
    unlock();
    wr(flash_seq_pkg::SFR_GCFG, 8'h00);
    rd(flash_seq_pkg::SFR_GCFG);
    chk(q, 8'h00);
    unlock();
    repeat (30) @(posedge aclk);
    wr(flash_seq_pkg::SFR_GCFG, 8'h84);
    rd(flash_seq_pkg::SFR_GCFG);
    chk(q, 8'h00);
    wr(flash_seq_pkg::SFR_DATA_LO, 8'h5C);
    cmd_chk(flash_seq_pkg::CMD_WRITE, 8'hFF, 8'h00);
    crd({flash_seq_pkg::DATA_PAGE, 8'hFE});
    chk(v[15:0], 16'h00A6);
  endtask
  task automatic t_id_pins();
    crd(flash_seq_pkg::ID_LOW_ADDR);
    chk(v[15:0], ID[15:0]);
    crd(flash_seq_pkg::ID_MID_ADDR);
    chk(v[15:0], ID[31:16]);
    crd(flash_seq_pkg::ID_TOP_ADDR);
    chk(v[15:0], {8'h00, ID[39:32]});
    axi_wr(flash_seq_pkg::REG_PINS, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk(prog_mode, 1'b1);
    axi_wr(flash_seq_pkg::REG_PINS, 32'h0000_0003);
    repeat (3) @(posedge aclk);
    chk(prog_mode, 1'b0);
    axi_wr(flash_seq_pkg::REG_PINS, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk(prog_mode, 1'b0);
  endtask
  // one programmer byte, msb first, one rising sck per bit
  task automatic sbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      axi_wr(flash_seq_pkg::REG_PINS, {28'h0000000, b[i], 3'h1});
      axi_wr(flash_seq_pkg::REG_PINS, {28'h0000000, b[i], 3'h5});
    end
  endtask
  task automatic t_prog();
    sbyte(flash_seq_pkg::PCMD_ERASE);
    repeat (8300) @(posedge aclk);
    crd(16'h0020);
    chk(v[15:0], 16'hFFFF);
    crd({flash_seq_pkg::DATA_PAGE, 8'hFE});
    chk(v[15:0], 16'h00FF);
    sbyte(flash_seq_pkg::PCMD_READ);
    axi_wr(flash_seq_pkg::REG_PINS, 32'h0000_0001);
    axi_wr(flash_seq_pkg::REG_PINS, 32'h0000_0005);
    axi_rd(flash_seq_pkg::REG_PINS);
    chk(v[4], 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_writes();
    t_bad_lock();
    t_id_pins();
    t_prog();
    print_verdict();
  end
endmodule
